// ===== ptc_pager_trap_ctrl.sv
// Pager trap and control: trap cause capture, trap word stores, forced trap
// vector, I/O command decode, base register reload and an APB status port.
// Assumes the mapping datapath gives mapped address and fault levels
// combinationally with each request, all on sys_clk_i.
`timescale 1ns/100ps

// Operation
// - Trap on table trap bits, absent page or table, illegal condition.
// - Trap when core status age has its top three bits zero.
// - On trap, first store status word at block word 571 octal.
// - Trapped write: then store its data at block word 572 octal.
// - Then force processor to 70, or 170 for second processor.
// - Status word: 18-bit address and nine request flags.
// - Cause bits 0-8; bits 0-1 pick group.
// - Group 0 flags age ranges and after-loading trap.
// - Group 1 flags not-in-core cases and excess indirection.
// - Group 2: absent page, entry traps, illegal access, limit.
// - Group 3 as group 2, for deeper tables.
// - After-loading trap only once loading is done.
// - I/O reset clears all; cleared pager maps nothing.
// - Answer device 24, decode three low command bits.
// - Command 0 flushes all and reloads from 71 and 72, or 171 and 172 for second processor.
// - Command 1 flushes exec entries, command 3 user entries.
// - Command 2 drops page of next write; that write not completed.
// - Commands 4 and 5 stop mapping, keeping registers.
// - Command 6 maps user and upper exec; 7 maps all from 20.
// - Reload word 1: monitor, accumulator, limit and user bases.
// - Limit code restricts user addresses.
// - Reload word 2 gives process-use and age.
// - Storage block is located by the monitor base.
module ptc_pager_trap_ctrl #(
  parameter int TRAP_CNT_W = 16
) (
  input  wire logic                       sys_clk_i,      // System clock
  input  wire logic                       reset_i,        // Async reset, high
  input  wire logic                       ce_i,           // Clock enable
  input  wire logic                       io_reset_i,     // I/O bus reset pulse
  input  wire logic                       cmd_valid_i,    // Command strobe
  input  wire logic [6:0]                 cmd_dev_i,      // Command device number
  input  wire logic [ptc_pkg::WORD_W-1:0] cmd_data_i,     // Command word
  input  ptc_pkg::ptc_req_s               cpu_req_i,      // Processor request
  input  ptc_pkg::ptc_flt_s               flt_i,          // Fault levels
  input  wire logic                       ar_loaded_i,    // Self-load finished
  input  wire logic [ptc_pkg::PA_W-1:0]   map_addr_i,     // Mapped address
  input  wire logic                       mem_ack_i,      // Memory done
  input  wire logic [ptc_pkg::WORD_W-1:0] mem_rdata_i,    // Memory read data
  input  wire logic                       psel_i,         // APB select
  input  wire logic                       penable_i,      // APB enable
  input  wire logic                       pwrite_i,       // APB write
  input  wire logic [ptc_pkg::APB_AW-1:0] paddr_i,        // APB address
  input  wire logic [31:0]                pwdata_i,       // APB write data
  input  wire logic [3:0]                 pstrb_i,        // APB strobes
  output ptc_pkg::ptc_mem_s               mem_o,          // Memory request
  output logic                            cpu_ack_o,      // Request done
  output logic [ptc_pkg::WORD_W-1:0]      cpu_rdata_o,    // Read data
  output logic                            cpu_trap_o,     // Force trap pulse
  output logic [ptc_pkg::EA_W-1:0]        cpu_trap_addr_o, // Trap vector
  output logic                            flush_all_o,    // Flush all AR
  output logic                            flush_exec_o,   // Flush exec AR
  output logic                            flush_user_o,   // Flush user AR
  output logic                            inval_page_o,   // Invalidate AR of req
  output ptc_pkg::ptc_map_s               map_en_o,       // Mapping enables
  output ptc_pkg::ptc_base_s              base_o,         // Base registers
  output logic                            pready_o,       // APB ready
  output logic [31:0]                     prdata_o,       // APB read data
  output logic                            pslverr_o       // APB error
);

  typedef struct packed {
    ptc_pkg::ptc_state_e        state;
    ptc_pkg::ptc_mem_s          mem;
    logic                       cpu_ack;
    logic [ptc_pkg::WORD_W-1:0] cpu_rdata;
    logic                       cpu_trap;
    logic [ptc_pkg::EA_W-1:0]   trap_addr;
    logic                       flush_all;
    logic                       flush_exec;
    logic                       flush_user;
    logic                       inval;
    logic                       armed;
    ptc_pkg::ptc_map_s          map;
    ptc_pkg::ptc_base_s         base;
    logic [ptc_pkg::WORD_W-1:0] tsw;
    logic [ptc_pkg::WORD_W-1:0] wsave;
    logic                       wr_trap;
    logic                       cmd_pend;
    logic [2:0]                 cmd_code;
    logic                       alt_cpu;
    logic [TRAP_CNT_W-1:0]      trap_cnt;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
  } ptc_st_s;

  localparam ptc_st_s S_INIT = '0;

  ptc_st_s s_q;
  ptc_st_s s_d;

  function automatic logic ptc_mapped(input ptc_pkg::ptc_map_s m,
                                      input logic em,
                                      input logic [ptc_pkg::EA_W-1:0] ea);
    return (ea >= ptc_pkg::MAP_LOW_LIMIT)
        && (em ? ((ea < ptc_pkg::RES_MON_END) ? m.res_en : m.exec_hi_en) : m.user_en);
  endfunction : ptc_mapped

  function automatic logic ptc_limit_viol(input logic [2:0] address_limit_reg,
                                          input logic em,
                                          input logic [ptc_pkg::EA_W-1:0] ea);
    logic [3:0] chunk;
    logic [3:0] top;
    chunk = ea[ptc_pkg::EA_W-1:ptc_pkg::LIM_LSB];
    top   = ptc_pkg::LIM_STEPS - {1'b0, address_limit_reg};
    return !em && (address_limit_reg != 3'h0) && (chunk >= top);
  endfunction : ptc_limit_viol

  // Returns {hit, cause}; cause bit 0 on top
  function automatic logic [9:0] ptc_cause(input ptc_pkg::ptc_flt_s f,
                                           input logic lim,
                                           input logic loaded);
    logic nic;
    logic pt;
    logic age;
    nic = f.shared_nic | f.pt_nic | f.ind2_priv_nic | f.ind_shared_nic
        | f.ind_pt_nic | f.excess_ind;
    pt  = f.priv_nic | f.write_copy | f.user_trap | f.access_trap
        | f.ill_rx | f.ill_w | f.fmt_err | lim;
    age = f.age_valid && (f.age_hi == 3'h0);
    if (nic) begin
      return {1'b1, ptc_pkg::GRP_NIC, 1'b0, f.shared_nic, f.pt_nic,
              f.ind2_priv_nic, f.ind_shared_nic, f.ind_pt_nic, f.excess_ind};
    end else if (pt) begin
      return {1'b1, (f.deep_level ? ptc_pkg::GRP_DEEP : ptc_pkg::GRP_PT1),
              f.priv_nic, f.write_copy, f.user_trap, f.access_trap,
              f.ill_rx, f.ill_w, f.fmt_err | lim};
    end else if (age || (f.after_load && loaded)) begin
      return {1'b1, ptc_pkg::GRP_AGE,
              age && (f.age_pair == 2'h0), age && (f.age_pair == 2'h1),
              age && (f.age_pair == 2'h2), age && (f.age_pair == 2'h3),
              f.after_load && loaded, 2'h0};
    end
    return 10'h000;
  endfunction : ptc_cause

  logic                     req_mapped;
  logic [9:0]               cause;
  logic [ptc_pkg::PA_W-1:0] psb_base;

  assign req_mapped = ptc_mapped(s_q.map, cpu_req_i.em, cpu_req_i.ea);
  assign cause      = ptc_cause(flt_i,
                                ptc_limit_viol(s_q.base.address_limit_reg, cpu_req_i.em, cpu_req_i.ea),
                                ar_loaded_i);
  assign psb_base   = {s_q.base.mbr, {ptc_pkg::OFS_W{1'b0}}};

  always_comb begin
    s_d            = s_q;
    s_d.cpu_ack    = 1'b0;
    s_d.cpu_trap   = 1'b0;
    s_d.flush_all  = 1'b0;
    s_d.flush_exec = 1'b0;
    s_d.flush_user = 1'b0;
    s_d.inval      = 1'b0;
    s_d.pready     = 1'b0;

    // One wait state: ready rises in the second access cycle
    if (psel_i && penable_i && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      case (paddr_i)
        ptc_pkg::A_CTRL: begin
          s_d.prdata = {31'h0000_0000, s_q.alt_cpu};
          if (pwrite_i && pstrb_i[0]) begin
            s_d.alt_cpu = pwdata_i[0];
          end
        end
        ptc_pkg::A_STATUS: begin
          s_d.prdata = {{(16 - TRAP_CNT_W){1'b0}}, s_q.trap_cnt, 8'h00,
                        (s_q.state != ptc_pkg::ST_IDLE), s_q.cmd_pend, s_q.armed,
                        2'h0, s_q.map};
        end
        ptc_pkg::A_TSW_HI: s_d.prdata = {28'h000_0000, s_q.tsw[35:32]};
        ptc_pkg::A_TSW_LO: s_d.prdata = s_q.tsw[31:0];
        ptc_pkg::A_BASE: begin
          s_d.prdata = {2'h0, s_q.base.mbr, s_q.base.acb, s_q.base.address_limit_reg, s_q.base.user_base_reg};
        end
        ptc_pkg::A_USE: s_d.prdata = {23'h00_0000, s_q.base.process_use_reg};
        ptc_pkg::A_AGE: s_d.prdata = {6'h00, s_q.base.age};
        default: s_d.pslverr = 1'b1;
      endcase
    end

    case (s_q.state)
      ptc_pkg::ST_IDLE: begin
        if (s_q.cmd_pend) begin
          s_d.cmd_pend = 1'b0;
          case (s_q.cmd_code)
            ptc_pkg::CMD_RELOAD: begin
              s_d.flush_all = 1'b1;
              s_d.mem.req   = 1'b1;
              s_d.mem.we    = 1'b0;
              s_d.mem.addr  = {11'h000, s_q.alt_cpu ? ptc_pkg::RELOAD1_B
                                                    : ptc_pkg::RELOAD1_A};
              s_d.state     = ptc_pkg::ST_RL1;
            end
            ptc_pkg::CMD_FLUSH_EXEC: s_d.flush_exec = 1'b1;
            ptc_pkg::CMD_ARM_INVAL:  s_d.armed      = 1'b1;
            ptc_pkg::CMD_FLUSH_USER: s_d.flush_user = 1'b1;
            ptc_pkg::CMD_OFF_A,
            ptc_pkg::CMD_OFF_B:      s_d.map = '0;
            ptc_pkg::CMD_MAP_UPPER:  s_d.map = 3'b110;
            ptc_pkg::CMD_MAP_ALL:    s_d.map = 3'b111;
            default: s_d.map = s_q.map;
          endcase
        end else if (cpu_req_i.valid) begin
          if (req_mapped && cause[9]) begin
            // Bit 0 of the word sits in bit 35
            s_d.tsw = {cause[8:0], cpu_req_i.em, cpu_req_i.ex, cpu_req_i.we,
                       cpu_req_i.rd, cpu_req_i.ind, cpu_req_i.pi, cpu_req_i.key,
                       flt_i.nxm, flt_i.parity, cpu_req_i.ea};
            s_d.wsave     = cpu_req_i.wdata;
            s_d.wr_trap   = cpu_req_i.we;
            s_d.trap_cnt  = s_q.trap_cnt + 1'b1;
            s_d.mem.req   = 1'b1;
            s_d.mem.we    = 1'b1;
            s_d.mem.addr  = psb_base | {11'h000, ptc_pkg::PSB_TSW_OFS};
            s_d.mem.wdata = s_d.tsw;
            s_d.state     = ptc_pkg::ST_TSW;
          end else if (req_mapped && s_q.armed && cpu_req_i.we) begin
            // Mapped write swallowed; its page's entry is dropped
            s_d.armed   = 1'b0;
            s_d.inval   = 1'b1;
            s_d.cpu_ack = 1'b1;
            s_d.state   = ptc_pkg::ST_DONE;
          end else begin
            s_d.mem.req   = 1'b1;
            s_d.mem.we    = cpu_req_i.we;
            s_d.mem.addr  = req_mapped ? map_addr_i : {2'h0, cpu_req_i.ea};
            s_d.mem.wdata = cpu_req_i.wdata;
            s_d.state     = ptc_pkg::ST_FWD;
          end
        end
      end
      ptc_pkg::ST_FWD: begin
        if (mem_ack_i) begin
          s_d.mem.req   = 1'b0;
          s_d.cpu_ack   = 1'b1;
          s_d.cpu_rdata = mem_rdata_i;
          s_d.state     = ptc_pkg::ST_DONE;
        end
      end
      ptc_pkg::ST_TSW: begin
        if (mem_ack_i) begin
          if (s_q.wr_trap) begin
            s_d.mem.addr  = psb_base | {11'h000, ptc_pkg::PSB_DATA_OFS};
            s_d.mem.wdata = s_q.wsave;
            s_d.state     = ptc_pkg::ST_TDAT;
          end else begin
            s_d.mem.req = 1'b0;
            s_d.state   = ptc_pkg::ST_TJMP;
          end
        end
      end
      ptc_pkg::ST_TDAT: begin
        if (mem_ack_i) begin
          s_d.mem.req = 1'b0;
          s_d.state   = ptc_pkg::ST_TJMP;
        end
      end
      ptc_pkg::ST_TJMP: begin
        // Only reached after all stores are acknowledged
        s_d.cpu_trap  = 1'b1;
        s_d.trap_addr = {9'h000, s_q.alt_cpu ? ptc_pkg::TRAP_VEC_B
                                             : ptc_pkg::TRAP_VEC_A};
        s_d.state     = ptc_pkg::ST_DONE;
      end
      ptc_pkg::ST_DONE: begin
        // Wait for the request to drop so it is not taken twice
        if (!cpu_req_i.valid) begin
          s_d.state = ptc_pkg::ST_IDLE;
        end
      end
      ptc_pkg::ST_RL1: begin
        if (mem_ack_i) begin
          s_d.base.address_limit_reg = mem_rdata_i[ptc_pkg::RL_ALR_LSB +: 3];
          s_d.base.mbr = mem_rdata_i[ptc_pkg::RL_MBR_LSB +: 11];
          s_d.base.acb = mem_rdata_i[ptc_pkg::RL_ACB_LSB +: 5];
          s_d.base.user_base_reg = mem_rdata_i[ptc_pkg::RL_UBR_LSB +: 11];
          s_d.mem.addr = {11'h000, s_q.alt_cpu ? ptc_pkg::RELOAD2_B
                                               : ptc_pkg::RELOAD2_A};
          s_d.state    = ptc_pkg::ST_RL2;
        end
      end
      ptc_pkg::ST_RL2: begin
        if (mem_ack_i) begin
          s_d.base.process_use_reg = mem_rdata_i[ptc_pkg::RL_PUR_LSB +: 9];
          s_d.base.age = mem_rdata_i[ptc_pkg::RL_AGE_LSB +: 26];
          s_d.mem.req  = 1'b0;
          s_d.state    = ptc_pkg::ST_IDLE;
        end
      end
      default: s_d.state = ptc_pkg::ST_IDLE;
    endcase

    // A new command beats consuming the pending one
    if (cmd_valid_i && (cmd_dev_i == ptc_pkg::IO_DEV_NUM)) begin
      s_d.cmd_pend = 1'b1;
      s_d.cmd_code = cmd_data_i[2:0];
    end

    if (io_reset_i) begin
      s_d = S_INIT;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= S_INIT;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign mem_o           = s_q.mem;
  assign cpu_ack_o       = s_q.cpu_ack;
  assign cpu_rdata_o     = s_q.cpu_rdata;
  assign cpu_trap_o      = s_q.cpu_trap;
  assign cpu_trap_addr_o = s_q.trap_addr;
  assign flush_all_o     = s_q.flush_all;
  assign flush_exec_o    = s_q.flush_exec;
  assign flush_user_o    = s_q.flush_user;
  assign inval_page_o    = s_q.inval;
  assign map_en_o        = s_q.map;
  assign base_o          = s_q.base;
  assign pready_o        = s_q.pready;
  assign prdata_o        = s_q.prdata;
  assign pslverr_o       = s_q.pslverr;

endmodule : ptc_pager_trap_ctrl

// ===== ptc_pkg.sv
// Constants, types and encodings for the pager trap and control block.
// Assumes one clock domain shared with the processor bus, memory bus and I/O bus.
package ptc_pkg;

  localparam int WORD_W = 36;
  localparam int EA_W   = 18;
  localparam int PA_W   = 20;
  localparam int OFS_W  = 9;
  localparam int APB_AW = 8;

  // Storage block word offsets (octal 571, 572)
  localparam logic [OFS_W-1:0] PSB_TSW_OFS  = 9'h179;
  localparam logic [OFS_W-1:0] PSB_DATA_OFS = 9'h17A;
  // Trap vector and reload words (octal 70/170, 71/171, 72/172)
  localparam logic [OFS_W-1:0] TRAP_VEC_A   = 9'h038;
  localparam logic [OFS_W-1:0] TRAP_VEC_B   = 9'h078;
  localparam logic [OFS_W-1:0] RELOAD1_A    = 9'h039;
  localparam logic [OFS_W-1:0] RELOAD1_B    = 9'h079;
  localparam logic [OFS_W-1:0] RELOAD2_A    = 9'h03A;
  localparam logic [OFS_W-1:0] RELOAD2_B    = 9'h07A;

  // I/O device number 24 (octal)
  localparam logic [6:0] IO_DEV_NUM = 7'h14;

  localparam logic [2:0] CMD_RELOAD     = 3'h0;
  localparam logic [2:0] CMD_FLUSH_EXEC = 3'h1;
  localparam logic [2:0] CMD_ARM_INVAL  = 3'h2;
  localparam logic [2:0] CMD_FLUSH_USER = 3'h3;
  localparam logic [2:0] CMD_OFF_A      = 3'h4;
  localparam logic [2:0] CMD_OFF_B      = 3'h5;
  localparam logic [2:0] CMD_MAP_UPPER  = 3'h6;
  localparam logic [2:0] CMD_MAP_ALL    = 3'h7;

  localparam logic [1:0] GRP_AGE  = 2'h0;
  localparam logic [1:0] GRP_NIC  = 2'h1;
  localparam logic [1:0] GRP_PT1  = 2'h2;
  localparam logic [1:0] GRP_DEEP = 2'h3;

  // Low unmapped area end and resident monitor top
  localparam logic [EA_W-1:0] MAP_LOW_LIMIT = 18'h0_0010;
  localparam logic [EA_W-1:0] RES_MON_END   = 18'h0_8000;
  // Limit: 16K chunk ea[17:14] must stay below 8 - code
  localparam int          LIM_LSB   = 14;
  localparam logic [3:0]  LIM_STEPS = 4'h8;

  // Reload word 1 fields (bit 35 is the word's bit 0)
  localparam int RL_ALR_LSB = 29;
  localparam int RL_MBR_LSB = 18;
  localparam int RL_ACB_LSB = 13;
  localparam int RL_UBR_LSB = 0;
  // Reload word 2 fields
  localparam int RL_PUR_LSB = 27;
  localparam int RL_AGE_LSB = 0;

  localparam logic [APB_AW-1:0] A_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] A_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] A_TSW_HI = 8'h08;
  localparam logic [APB_AW-1:0] A_TSW_LO = 8'h0C;
  localparam logic [APB_AW-1:0] A_BASE   = 8'h10;
  localparam logic [APB_AW-1:0] A_USE    = 8'h14;
  localparam logic [APB_AW-1:0] A_AGE    = 8'h18;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FWD, ST_TSW, ST_TDAT, ST_TJMP, ST_DONE, ST_RL1, ST_RL2
  } ptc_state_e;

  typedef struct packed {
    logic            valid;
    logic            rd;
    logic            we;
    logic            ex;
    logic            em;
    logic            ind;
    logic            pi;
    logic            key;
    logic [EA_W-1:0] ea;
    logic [WORD_W-1:0] wdata;
  } ptc_req_s;

  typedef struct packed {
    logic       shared_nic;
    logic       pt_nic;
    logic       ind2_priv_nic;
    logic       ind_shared_nic;
    logic       ind_pt_nic;
    logic       excess_ind;
    logic       priv_nic;
    logic       write_copy;
    logic       user_trap;
    logic       access_trap;
    logic       ill_rx;
    logic       ill_w;
    logic       fmt_err;
    logic       deep_level;
    logic       nxm;
    logic       parity;
    logic       age_valid;
    logic [2:0] age_hi;
    logic [1:0] age_pair;
    logic       after_load;
  } ptc_flt_s;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [PA_W-1:0]   addr;
    logic [WORD_W-1:0] wdata;
  } ptc_mem_s;

  typedef struct packed {
    logic user_en;
    logic exec_hi_en;
    logic res_en;
  } ptc_map_s;

  typedef struct packed {
    logic [10:0] mbr;
    logic [4:0]  acb;
    logic [2:0]  address_limit_reg;
    logic [10:0] user_base_reg;
    logic [8:0]  process_use_reg;
    logic [25:0] age;
  } ptc_base_s;

endpackage : ptc_pkg

// ===== ptc_assertions.sv
// Concurrent checks on the pager trap and control ports.
// Assumes binding onto ptc_pager_trap_ctrl, one clock, reset_i active high.
`timescale 1ns/100ps
module ptc_assertions (
  input wire logic        sys_clk_i,       // Clock
  input wire logic        reset_i,         // Async reset
  input wire logic        ce_i,            // Clock enable
  input wire logic        io_reset_i,      // I/O bus reset
  input wire logic        cmd_valid_i,     // Command strobe
  input wire logic [6:0]  cmd_dev_i,       // Device number
  input wire logic [35:0] cmd_data_i,      // Command word
  input ptc_pkg::ptc_req_s  cpu_req_i,     // Processor request
  input ptc_pkg::ptc_mem_s  mem_o,         // Memory request
  input wire logic        cpu_ack_o,       // Request done
  input wire logic        cpu_trap_o,      // Trap pulse
  input wire logic [17:0] cpu_trap_addr_o, // Trap vector
  input wire logic        flush_all_o,     // Flush all
  input wire logic        flush_exec_o,    // Flush exec
  input wire logic        inval_page_o,    // Invalidate page
  input ptc_pkg::ptc_map_s  map_en_o,      // Mapping enables
  input ptc_pkg::ptc_base_s base_o         // Base registers
);
  logic cmd_ok;
  assign cmd_ok = cmd_valid_i && cmd_dev_i == ptc_pkg::IO_DEV_NUM;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  chk_trap_clean: assert property (
    cpu_trap_o |-> !cpu_ack_o && !mem_o.req && !$past(mem_o.req)) else $error("trap not clean");
  chk_trap_vector: assert property (
    cpu_trap_o |-> cpu_trap_addr_o inside {18'h0_0038, 18'h0_0078}) else $error("bad vector");
  chk_store_order: assert property (
    cpu_trap_o |-> $past(mem_o.addr, 2) == {base_o.mbr, cpu_req_i.we ?
      ptc_pkg::PSB_DATA_OFS : ptc_pkg::PSB_TSW_OFS}) else $error("last store address wrong");
  chk_inval_write: assert property (
    inval_page_o |-> cpu_ack_o && cpu_req_i.we && !mem_o.req) else $error("bad invalidate");
  chk_io_clear: assert property (
    io_reset_i && ce_i |=> map_en_o == '0 && base_o == '0 && !cpu_trap_o) else $error("no clear");
  chk_flush_exec: assert property (
    cmd_ok && cmd_data_i[2:0] == ptc_pkg::CMD_FLUSH_EXEC |-> ##[1:40] flush_exec_o)
    else $error("exec flush missing");
  chk_map_off: assert property (
    cmd_ok && cmd_data_i[2:1] == 2'h2 |-> ##[1:40] map_en_o == '0) else $error("map not off");
  chk_reload_addr: assert property (
    flush_all_o |-> mem_o.req && !mem_o.we && mem_o.addr inside {20'h0_0039, 20'h0_0079})
    else $error("bad reload read");
  cover property (cpu_trap_o);
  cover property (inval_page_o);
  cover property (flush_all_o);
endmodule : ptc_assertions

bind ptc_pager_trap_ctrl ptc_assertions ptc_assertions_i (.sys_clk_i, .reset_i, .ce_i,
  .io_reset_i, .cmd_valid_i, .cmd_dev_i, .cmd_data_i, .cpu_req_i, .mem_o, .cpu_ack_o,
  .cpu_trap_o, .cpu_trap_addr_o, .flush_all_o, .flush_exec_o, .inval_page_o, .map_en_o, .base_o);

// ===== ptc_mem_model.sv
// Core memory behind the pager: word store with a set answer delay.
// Assumes the request stays up until the acknowledge edge.
`timescale 1ns/100ps
module ptc_mem_model (
  input  wire logic        sys_clk_i, // Clock
  input  wire logic        reset_i,   // Async reset
  input  ptc_pkg::ptc_mem_s mem_i,    // Request
  input  wire logic [3:0]  dly_i,     // Extra wait cycles
  output logic             ack_o,     // Done pulse
  output logic [35:0]      rdata_o    // Read data
);
  logic [35:0] mem [logic [19:0]];
  int unsigned wcnt = 0;
  logic [3:0]  cnt;
  // Data lines invert once after each answer so stale data never looks valid
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      cnt <= '0;
      rdata_o <= '0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= '0;
      rdata_o <= ~rdata_o;
    end else if (mem_i.req && cnt >= dly_i) begin
      ack_o <= 1'b1;
      if (mem_i.we) begin
        mem[mem_i.addr] = mem_i.wdata;
        wcnt++;
      end else begin
        rdata_o <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : '0;
      end
    end else if (mem_i.req) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ptc_mem_model

// ===== ptc_pager_trap_ctrl_tb_top.sv
// Self-checking bench for the pager trap and control block.
// Assumes ptc_mem_model answers memory requests; one 20 MHz clock.
`timescale 1ns/100ps
module ptc_pager_trap_ctrl_tb_top;
  typedef struct packed {
    logic [6:0] dev;
    logic [2:0] cmd;
    logic [1:0] fl;
    logic [2:0] map;
  } ptc_row_s;
  ptc_row_s rows [8] = '{'{7'h14, 3'h7, 2'h0, 3'h7}, '{7'h14, 3'h1, 2'h2, 3'h7},
    '{7'h14, 3'h3, 2'h1, 3'h7}, '{7'h15, 3'h4, 2'h0, 3'h7}, '{7'h14, 3'h5, 2'h0, 3'h0},
    '{7'h14, 3'h6, 2'h0, 3'h6}, '{7'h14, 3'h4, 2'h0, 3'h0}, '{7'h14, 3'h7, 2'h0, 3'h7}};
  logic               sys_clk_i = 1'b0;
  logic               reset_i = 1'b1;
  logic               io_reset_i = 1'b0;
  logic               cmd_valid_i = 1'b0;
  logic [6:0]         cmd_dev_i = '0;
  logic [35:0]        cmd_data_i = '0;
  ptc_pkg::ptc_req_s  cpu_req_i = '0;
  ptc_pkg::ptc_flt_s  flt_i = '0;
  logic               psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]         paddr_i = '0;
  logic [31:0]        pwdata_i = '0, prdata_o, rd;
  logic [3:0]         dly = 4'h3;
  logic [35:0]        mem_rdata_i, cpu_rdata_o;
  logic [17:0]        cpu_trap_addr_o, va;
  logic [2:0]         obs;
  logic [1:0]         fl;
  logic               mem_ack_i, cpu_ack_o, cpu_trap_o, flush_all_o, flush_exec_o, flush_user_o;
  logic               inval_page_o, pready_o, pslverr_o, err, trap;
  ptc_pkg::ptc_mem_s  mem_o;
  ptc_pkg::ptc_map_s  map_en_o;
  ptc_pkg::ptc_base_s base_o;
  int                 mismatches = 0, n_tests = 0, cyc = 0;

  ptc_pager_trap_ctrl ptc_pager_trap_ctrl_i (.sys_clk_i, .reset_i, .ce_i(1'b1), .io_reset_i,
    .cmd_valid_i, .cmd_dev_i, .cmd_data_i, .cpu_req_i, .flt_i, .ar_loaded_i(1'b0),
    .map_addr_i(20'h4_5678), .mem_ack_i, .mem_rdata_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i(4'hF), .mem_o, .cpu_ack_o, .cpu_rdata_o, .cpu_trap_o,
    .cpu_trap_addr_o, .flush_all_o, .flush_exec_o, .flush_user_o, .inval_page_o, .map_en_o,
    .base_o, .pready_o, .prdata_o, .pslverr_o);
  ptc_mem_model ptc_mem_model_i (.sys_clk_i, .reset_i, .mem_i(mem_o), .dly_i(dly),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Upper command bits are noise; only the low three count
  task automatic send_cmd(input logic [6:0] dev, input logic [2:0] cmd);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_dev_i <= dev;
    cmd_data_i <= {33'h1_5A5A_5A5A, cmd};
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    fl = '0;
    repeat (8) begin
      @(posedge sys_clk_i);
      fl |= {flush_exec_o, flush_user_o};
    end
  endtask : send_cmd

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic cpu(input logic we, input logic [17:0] ea);
    @(posedge sys_clk_i);
    cpu_req_i <= '{valid: 1'b1, rd: !we, we: we, ea: ea, wdata: {18'h2_AAAA, ea}, default: '0};
    do @(posedge sys_clk_i); while (cpu_ack_o !== 1'b1 && cpu_trap_o !== 1'b1);
    obs = {cpu_trap_o, cpu_ack_o, inval_page_o};
    va = cpu_trap_addr_o;
    cpu_req_i.valid <= 1'b0;
    flt_i <= '0;
    repeat (2) @(posedge sys_clk_i);
  endtask : cpu

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    ptc_mem_model_i.mem[20'h0_0039] = {4'h0, 3'h6, 11'h123, 5'h0A, 2'h0, 11'h456};
    ptc_mem_model_i.mem[20'h0_003A] = {9'h1A5, 1'h0, 26'h2AB_CDEF};
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    chk({map_en_o, base_o, cpu_trap_o}, '0);
    send_cmd(7'h14, ptc_pkg::CMD_RELOAD);
    repeat (12) @(posedge sys_clk_i);
    chk(base_o, {11'h123, 5'h0A, 3'h6, 11'h456, 9'h1A5, 26'h2AB_CDEF});
    dly = 4'h0;
    foreach (rows[i]) begin
      send_cmd(rows[i].dev, rows[i].cmd);
      chk(fl, rows[i].fl);
      chk(map_en_o, rows[i].map);
    end
    flt_i <= '{priv_nic: 1'b1, default: '0};
    cpu(1'b1, 18'h0_2345);
    chk({obs, va}, {3'h4, 18'h0_0038});
    chk(ptc_mem_model_i.mem[{11'h123, 9'h179}], {9'h140, 9'h040, 18'h0_2345});
    chk(ptc_mem_model_i.mem[{11'h123, 9'h17A}], {18'h2_AAAA, 18'h0_2345});
    chk(ptc_mem_model_i.wcnt, 32'h2);
    apb(1'b1, ptc_pkg::A_CTRL, 32'h0000_0001);
    apb(1'b0, ptc_pkg::A_CTRL, '0);
    chk({err, rd}, 33'h0_0000_0001);
    flt_i <= '{age_valid: 1'b1, age_pair: 2'h1, default: '0};
    cpu(1'b0, 18'h0_0100);
    chk({obs, va}, {3'h4, 18'h0_0078});
    chk(ptc_mem_model_i.mem[{11'h123, 9'h179}], {9'h020, 9'h020, 18'h0_0100});
    chk(ptc_mem_model_i.wcnt, 32'h3);
    apb(1'b0, ptc_pkg::A_TSW_LO, '0);
    chk({err, rd}, {1'h0, 5'h0, 9'h020, 18'h0_0100});
    apb(1'b0, 8'h40, '0);
    chk({err, rd}, 33'h1_0000_0000);
    send_cmd(7'h14, ptc_pkg::CMD_ARM_INVAL); // no interrupts here
    cpu(1'b1, 18'h0_3000);
    chk(obs, 3'h3);
    chk(ptc_mem_model_i.wcnt, 32'h3);
    cpu(1'b1, 18'h0_3000);
    chk(obs, 3'h2);
    chk(ptc_mem_model_i.mem[20'h4_5678], {18'h2_AAAA, 18'h0_3000});
    @(posedge sys_clk_i);
    io_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    io_reset_i <= 1'b0;
    @(posedge sys_clk_i);
    chk({map_en_o, base_o}, '0);
    flt_i <= '{priv_nic: 1'b1, default: '0};
    cpu(1'b1, 18'h0_2345);
    chk(obs, 3'h2);
    chk(ptc_mem_model_i.mem[20'h0_2345], {18'h2_AAAA, 18'h0_2345});
    cpu(1'b0, 18'h0_2345);
    chk(cpu_rdata_o, {18'h2_AAAA, 18'h0_2345});
    close_out();
  end
endmodule : ptc_pager_trap_ctrl_tb_top
